/* ats_pkg.sv */
// constants shared by the asynchronous timer register block
// assumes a 100 MHz register clock and 32-bit AXI4-Lite data
package ats_pkg;
   // ==========================================================
   // clock and timing
   localparam int CLK_MHZ = 100;
   localparam int SYNC_NS = 40;
   localparam int CLKSW_NS = 60;
   localparam logic [3:0] SYNC_CYC = 4'((SYNC_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] CLKSW_CYC = 4'((CLKSW_NS * CLK_MHZ + 999) / 1000);
   // ==========================================================
   // register offsets (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_SCLR = 8'h0C;
   localparam logic [7:0] OFS_IEN_SET = 8'h10;
   localparam logic [7:0] OFS_IEN_CLR = 8'h14;
   localparam logic [7:0] OFS_IMASK = 8'h18;
   localparam logic [7:0] OFS_WAKE = 8'h1C;
   localparam logic [7:0] OFS_ALARM_MATCH_0 = 8'h20;
   localparam logic [7:0] OFS_PER_SEL = 8'h30;
   localparam logic [7:0] OFS_CLOCK = 8'h40;
   // ==========================================================
   // field positions
   localparam int BIT_EN = 0;
   localparam int BIT_PRESCALER_RESET_BIT = 1;
   localparam int BIT_CA0 = 8;
   localparam int POS_PSEL = 16;
   localparam int BIT_WRAP = 0;
   localparam int BIT_ALARM = 8;
   localparam int BIT_PER = 16;
   localparam int BIT_BUSY = 24;
   localparam int BIT_READY = 25;
   localparam int BIT_CLOCK_SWITCH_PENDING = 28;
   localparam int BIT_CLKDONE = 29;
   localparam int BIT_CLK_ON = 0;
   // ==========================================================
   // field masks and reset values
   localparam logic [31:0] CTRL_MASK = 32'h000F_0101;
   localparam logic [31:0] STAT_MASK = 32'h2201_0101;
   localparam logic [31:0] WAKE_MASK = 32'h0001_0101;
   localparam logic [31:0] SEL_MASK = 32'h0000_000F;
   localparam logic [31:0] RST_VAL = 32'h0000_0000;
   localparam int PRESC_W = 16;
   // ==========================================================
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* ats_sleep_model.sv */
// sleep controller model that sits on the wake request of the timer
// assumes sleep_req is a one-cycle pulse on aclk from the bench
`timescale 1ns/1ps
`default_nettype none
module ats_sleep_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // requests
   input wire logic sleep_req,
   input wire logic wake_req,
   // state
   output logic asleep
);
   // ==========================================================
   // sleep state
   // a pending wake turns a sleep request back at once, so software
   // must drop the wake source before it sleeps again
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         asleep <= 1'b0;
      end else if (wake_req) begin
         asleep <= 1'b0;
      end else if (sleep_req) begin
         asleep <= 1'b1;
      end
   end
endmodule // ats_sleep_model
`default_nettype wire

/* ats_sync_track.sv */
// busy tracker for a value crossing into the prescaler side
// assumes start is a one-cycle pulse on aclk
`timescale 1ns/1ps
`default_nettype none
module ats_sync_track
   import ats_pkg::*;
#(
   parameter logic [3:0] LOAD = SYNC_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic start,
   // state
   output logic busy,
   output logic done
);
   logic [3:0] cnt_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 4'h0;
      end else if (start && cnt_q == 4'h0) begin
         cnt_q <= LOAD;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end

   assign busy = (cnt_q != 4'h0);
   // marks the edge at which busy falls
   assign done = (cnt_q == 4'h1);
endmodule // ats_sync_track
`default_nettype wire

/* ats_timer.sv */
// asynchronous timer register block: control, counter, status, mask
// assumes an AXI4-Lite master on aclk and a sleep controller on wake_req
// Function
// - writing one to prescaler clear resets prescaler; bit reads zero
// - enable bit zero stops counting, one lets the counter run
// - counter value reads full 32-bit count; accepted write loads it
// - while busy, writes to synchronized registers are discarded
// - while busy, synchronized readable registers read as zero
// - ready flag sets when busy falls, stays until cleared
// - clock-done flag sets when clock busy falls, stays until cleared
// - clock busy reads one after clock enable write while pending
// - periodic flag sets on rising edge of selected prescaler bit
// - alarm flag sets when counter reaches alarm compare value
// - wrap flag sets when counter overflows, stays until cleared
// - one in status clear drops matching flag and its request
// - one in irq enable set sets matching mask bit
// - one in irq enable clear clears matching mask bit
// - irq mask reads one per enabled source, status bit layout
// - periodic event with its wake bit raises the wake request
// - alarm match with its wake bit raises the wake request
// - wrap with its wake bit raises wake; without it no wake
// - clear-on-alarm bit set resets counter on alarm match
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ats_timer
   import ats_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   // axi write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   // axi read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // system
   output logic irq,
   output logic wake_req
);
   // ==========================================================
   // state
   logic aw_ok_q, w_ok_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q, raddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] ctrl_q, count_q, status_q, mask_q, wake_q, alarm_q;
   logic [31:0] psel_q;
   logic clock_on_q;
   logic [PRESC_W-1:0] presc_q;
   logic cnt_bit_q, per_bit_q;
   // combinational
   logic [31:0] wmask, wd, ev, clr, rd_mux;
   logic wr_fire, wr_sync, wr_map, wr_ok, rd_take;
   logic busy, sync_done, clk_busy, clk_done, sync_start;
   logic we_ctrl, we_count, we_sclr, we_iset, we_iclr, we_wake;
   logic we_alarm, we_sel, we_clock, prescaler_reset_bit;
   logic cnt_rise, per_rise, cnt_tick, alarm_hit, wrap_hit;
   logic [31:0] count_next;

   // ==========================================================
   // address decode helpers
   function automatic logic is_sync(input logic [7:0] a);
      is_sync = (a == OFS_CTRL) || (a == OFS_COUNT) || (a == OFS_SCLR)
         || (a == OFS_WAKE) || (a == OFS_ALARM_MATCH_0) || (a == OFS_PER_SEL);
   endfunction

   function automatic logic is_map(input logic [7:0] a);
      is_map = is_sync(a) || (a == OFS_STATUS) || (a == OFS_IEN_SET)
         || (a == OFS_IEN_CLR) || (a == OFS_IMASK) || (a == OFS_CLOCK);
   endfunction

   // ==========================================================
   // axi write channel
   assign awready = !aw_ok_q && !bvalid_q;
   assign wready = !w_ok_q && !bvalid_q;
   assign wr_fire = aw_ok_q && w_ok_q && !bvalid_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_q <= 1'b0;
         w_ok_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= RST_VAL;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_ok_q <= 1'b1;
            awaddr_q <= {awaddr[7:2], 2'b00};
         end
         if (wvalid && wready) begin
            w_ok_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_fire) begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask[8*gi +: 8] = {8{wstrb_q[gi]}};
      end
   endgenerate

   assign wd = wdata_q & wmask;
   assign wr_map = is_map(awaddr_q);
   assign wr_sync = is_sync(awaddr_q);
   // a discarded write still answers okay: software polls busy instead
   assign wr_ok = wr_fire && wr_map && !(wr_sync && busy);
   assign sync_start = wr_ok && wr_sync;
   assign we_ctrl = wr_ok && awaddr_q == OFS_CTRL;
   assign we_count = wr_ok && awaddr_q == OFS_COUNT;
   assign we_sclr = wr_ok && awaddr_q == OFS_SCLR;
   assign we_iset = wr_ok && awaddr_q == OFS_IEN_SET;
   assign we_iclr = wr_ok && awaddr_q == OFS_IEN_CLR;
   assign we_wake = wr_ok && awaddr_q == OFS_WAKE;
   assign we_alarm = wr_ok && awaddr_q == OFS_ALARM_MATCH_0;
   assign we_sel = wr_ok && awaddr_q == OFS_PER_SEL;
   assign we_clock = wr_ok && awaddr_q == OFS_CLOCK;
   assign prescaler_reset_bit = we_ctrl && wd[BIT_PRESCALER_RESET_BIT];

   // ==========================================================
   // synchronization trackers
   ats_sync_track #(.LOAD(SYNC_CYC)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(sync_start),
      .busy(busy),
      .done(sync_done)
   );

   ats_sync_track #(.LOAD(CLKSW_CYC)) u_clksw (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(we_clock),
      .busy(clk_busy),
      .done(clk_done)
   );

   // ==========================================================
   // software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= RST_VAL;
         wake_q <= RST_VAL;
         alarm_q <= RST_VAL;
         psel_q <= RST_VAL;
         clock_on_q <= 1'b0;
      end else begin
         // prescaler clear is a strobe and is never stored
         if (we_ctrl)
            ctrl_q <= ((ctrl_q & ~wmask) | wd) & CTRL_MASK;
         if (we_wake)
            wake_q <= ((wake_q & ~wmask) | wd) & WAKE_MASK;
         if (we_alarm)
            alarm_q <= (alarm_q & ~wmask) | wd;
         if (we_sel)
            psel_q <= ((psel_q & ~wmask) | wd) & SEL_MASK;
         if (we_clock && wstrb_q[0])
            clock_on_q <= wdata_q[BIT_CLK_ON];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= RST_VAL;
      end else if (we_iset) begin
         mask_q <= mask_q | (wd & STAT_MASK);
      end else if (we_iclr) begin
         mask_q <= mask_q & ~wd;
      end
   end

   // ==========================================================
   // prescaler and counter
   // a change of select may give one spurious tick; accepted trade-off
   assign cnt_rise = presc_q[ctrl_q[POS_PSEL +: 4]] && !cnt_bit_q;
   assign per_rise = presc_q[psel_q[3:0]] && !per_bit_q;
   assign cnt_tick = cnt_rise && ctrl_q[BIT_EN];
   assign alarm_hit = cnt_tick && (count_next == alarm_q);
   assign wrap_hit = cnt_tick && (count_q == 32'hFFFF_FFFF);
   assign count_next = count_q + 32'h0000_0001;

   always_ff @(posedge aclk) begin
      if (!aresetn || prescaler_reset_bit) begin
         presc_q <= '0;
         cnt_bit_q <= 1'b0;
         per_bit_q <= 1'b0;
      end else if (clock_on_q) begin
         presc_q <= presc_q + 16'h0001;
         cnt_bit_q <= presc_q[ctrl_q[POS_PSEL +: 4]];
         per_bit_q <= presc_q[psel_q[3:0]];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= RST_VAL;
      end else if (we_count) begin
         count_q <= (count_q & ~wmask) | wd;
      end else if (cnt_tick) begin
         if (ctrl_q[BIT_CA0] && count_q == alarm_q)
            count_q <= RST_VAL;
         else
            count_q <= count_next;
      end
   end

   // ==========================================================
   // status flags: a new event wins over a clear in the same cycle
   always_comb begin
      ev = RST_VAL;
      ev[BIT_WRAP] = wrap_hit;
      ev[BIT_ALARM] = alarm_hit;
      ev[BIT_PER] = per_rise && clock_on_q;
      ev[BIT_READY] = sync_done;
      ev[BIT_CLKDONE] = clk_done;
   end

   assign clr = we_sclr ? (wd & STAT_MASK) : RST_VAL;

   always_ff @(posedge aclk) begin
      if (!aresetn)
         status_q <= RST_VAL;
      else
         status_q <= (status_q & ~clr) | ev;
   end

   assign irq = |(status_q & mask_q);
   // dropped by software clearing the status bit or its wake enable bit
   assign wake_req = |(status_q & wake_q);

   // ==========================================================
   // axi read channel
   assign arready = !rvalid_q;
   assign rd_take = arvalid && arready;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   always_comb begin
      rd_mux = RST_VAL;
      case ({araddr[7:2], 2'b00})
         OFS_CTRL: rd_mux = ctrl_q;
         OFS_COUNT: rd_mux = count_q;
         OFS_STATUS: begin
            rd_mux = status_q;
            rd_mux[BIT_BUSY] = busy;
            rd_mux[BIT_CLOCK_SWITCH_PENDING] = clk_busy;
         end
         OFS_IMASK: rd_mux = mask_q;
         OFS_WAKE: rd_mux = wake_q;
         OFS_ALARM_MATCH_0: rd_mux = alarm_q;
         OFS_PER_SEL: rd_mux = psel_q;
         OFS_CLOCK: rd_mux[BIT_CLK_ON] = clock_on_q;
         default: rd_mux = RST_VAL;
      endcase
      if (busy && is_sync({araddr[7:2], 2'b00}))
         rd_mux = RST_VAL;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= RST_VAL;
         rresp_q <= RESP_OKAY;
         raddr_q <= 8'h00;
      end else if (rd_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         raddr_q <= {araddr[7:2], 2'b00};
         rresp_q <= is_map({araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_prescaler_reset_bit_reads_zero: assert property (
      (rvalid_q && raddr_q == OFS_CTRL) |-> !rdata_q[BIT_PRESCALER_RESET_BIT])
      else $error("prescaler clear bit read back as one");
   a_stop_when_off: assert property (
      (!ctrl_q[BIT_EN] && !we_count) |=> $stable(count_q))
      else $error("counter moved while disabled");
   a_count_load: assert property (
      we_count && wstrb_q == 4'hF |=> count_q == $past(wdata_q))
      else $error("counter write not loaded");
   a_busy_discard: assert property (
      (wr_fire && busy && awaddr_q == OFS_ALARM_MATCH_0) |=> $stable(alarm_q))
      else $error("alarm written while busy");
   a_busy_read_zero: assert property (
      (rd_take && busy && is_sync({araddr[7:2], 2'b00})) |=> rdata_q == 0)
      else $error("synchronized register read nonzero while busy");
   a_ready_on_fall: assert property (
      $fell(busy) |-> status_q[BIT_READY])
      else $error("ready flag missing after busy fell");
   a_clkdone_on_fall: assert property (
      $fell(clk_busy) |-> status_q[BIT_CLKDONE])
      else $error("clock done flag missing after clock busy fell");
   a_clk_busy_span: assert property (
      (we_clock && !clk_busy) |=> clk_busy [*6] ##1 !clk_busy)
      else $error("clock busy span wrong");
   a_per_flag: assert property (
      (per_rise && clock_on_q) |=> status_q[BIT_PER])
      else $error("periodic flag not set");
   a_alarm_flag: assert property (
      (alarm_hit && !wr_ok) |=> status_q[BIT_ALARM] && count_q == alarm_q)
      else $error("alarm flag not set on match");
   a_wrap_flag: assert property (
      (wrap_hit && !we_count) |=> status_q[BIT_WRAP] && count_q == 0)
      else $error("wrap flag not set on overflow");
   a_clear_flag: assert property (
      (we_sclr && wd[BIT_ALARM] && !alarm_hit) |=> !status_q[BIT_ALARM])
      else $error("status clear did not clear alarm flag");
   a_mask_set: assert property (
      (we_iset && wd[BIT_WRAP]) |=> mask_q[BIT_WRAP])
      else $error("irq mask bit not set");
   a_mask_clear: assert property (
      (we_iclr && wd[BIT_PER]) |=> !mask_q[BIT_PER])
      else $error("irq mask bit not cleared");
   a_wake_gate: assert property (
      (status_q[BIT_WRAP] && wake_q[BIT_WRAP]) |-> wake_req)
      else $error("wrap wake not raised");
   a_clear_on_alarm: assert property (
      (cnt_tick && ctrl_q[BIT_CA0] && count_q == alarm_q && !we_count)
      |=> count_q == 0)
      else $error("counter not cleared on alarm");
   a_irq_level: assert property (
      (status_q[BIT_ALARM] && mask_q[BIT_ALARM]) |-> irq)
      else $error("irq low with enabled flag set");
   a_busy_span: assert property (
      sync_start |=> busy [*4] ##1 !busy)
      else $error("busy span wrong");

   c_sync_write: cover property (sync_start ##[1:10] $fell(busy));
   c_alarm_wake: cover property (alarm_hit && wake_q[BIT_ALARM]);
   c_clear_race: cover property (we_sclr && |(wd & ev));
endmodule // ats_timer
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the asynchronous timer register block
// assumes ats_timer behind an AXI4-Lite slave port on a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ats_pkg::*;
   // ==========================================================
   // signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, sleep_req = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awready, wready, bvalid, arready, rvalid, irq, wake_req, asleep;
   logic [1:0] bresp, rresp, last_b, last_r;
   logic [31:0] rdata, v, c0;
   int failures = 0;
   int cmp_count = 0;

   ats_timer dut_u (
      .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
      .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
      .rdata, .rresp, .irq, .wake_req
   );
   ats_sleep_model sleep_u (
      .aclk, .aresetn, .sleep_req, .wake_req, .asleep
   );

   initial begin
      forever #5 aclk = ~aclk;
   end

   // ==========================================================
   // bus tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      last_b = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      last_r = rresp;
      rready <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   // polls status until the given bit reads the given level
   task automatic wait_st(input int pos, input logic lvl);
      do rd(OFS_STATUS, v); while (v[pos] !== lvl);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // whole sequence needs a few hundred cycles
   initial begin
      #200000;
      failures++;
      wrap_up();
   end

   // ==========================================================
   // tests
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_CTRL, v);
      chk("control reset", v, RST_VAL);
      rd(OFS_COUNT, v);
      chk("counter reset", v, RST_VAL);
      rd(OFS_STATUS, v);
      chk("status reset", v, RST_VAL);
      rd(OFS_IMASK, v);
      chk("mask reset", v, RST_VAL);
      rd(OFS_WAKE, v);
      chk("wake reset", v, RST_VAL);
      rd(OFS_ALARM_MATCH_0, v);
      chk("alarm reset", v, RST_VAL);
      rd(8'h60, v);
      chk("unmapped read resp", {30'h0, last_r}, {30'h0, RESP_SLVERR});
      wr(8'h60, 32'h1234_5678);
      chk("unmapped write resp", {30'h0, last_b}, {30'h0, RESP_SLVERR});
      // mask set of all sources, then a clear that leaves untouched bits alone
      wr(OFS_IEN_SET, 32'h2201_0101);
      rd(OFS_IMASK, v);
      chk("mask set", v, 32'h2201_0101);
      wr(OFS_IEN_CLR, 32'h2201_0000);
      rd(OFS_IMASK, v);
      chk("mask clear", v, 32'h0000_0101);
      // busy window after a synchronized write
      wr(OFS_WAKE, 32'h0000_0001);
      rd(OFS_STATUS, v);
      chk("busy raised", {31'h0, v[BIT_BUSY]}, 32'h1);
      wait_st(BIT_BUSY, 1'b0);
      chk("ready after busy", {31'h0, v[BIT_READY]}, 32'h1);
      wr(OFS_ALARM_MATCH_0, 32'h0000_0003);
      wr(OFS_ALARM_MATCH_0, 32'h0000_0009);
      wait_st(BIT_BUSY, 1'b0);
      rd(OFS_ALARM_MATCH_0, v);
      chk("write dropped while busy", v, 32'h0000_0003);
      wr(OFS_COUNT, 32'hFFFF_FFFE);
      rd(OFS_COUNT, v);
      chk("reads zero while busy", v, 32'h0);
      wait_st(BIT_BUSY, 1'b0);
      rd(OFS_COUNT, v);
      chk("counter load", v, 32'hFFFF_FFFE);
      // periodic select is a synchronized register of its own
      wr(OFS_PER_SEL, 32'h0000_0004);
      wait_st(BIT_BUSY, 1'b0);
      rd(OFS_PER_SEL, v);
      chk("periodic select", v, 32'h0000_0004);
      // prescaler clock switch
      wr(OFS_CLOCK, 32'h0000_0001);
      rd(OFS_STATUS, v);
      chk("clock busy", {31'h0, v[BIT_CLOCK_SWITCH_PENDING]}, 32'h1);
      wait_st(BIT_CLKDONE, 1'b1);
      chk("clock busy fell", {31'h0, v[BIT_CLOCK_SWITCH_PENDING]}, 32'h0);
      // run through wrap and alarm with clear-on-alarm, prescaler bit 1
      wr(OFS_CTRL, 32'h0001_0101);
      wait_st(BIT_BUSY, 1'b0);
      repeat (40) @(posedge aclk);
      rd(OFS_STATUS, v);
      chk("events", v & 32'h0001_0101, 32'h0001_0101);
      chk("irq", {31'h0, irq}, 32'h1);
      chk("wake", {31'h0, wake_req}, 32'h1);
      rd(OFS_COUNT, v);
      chk("clear on alarm", {31'h0, v <= 32'h3}, 32'h1);
      @(posedge aclk) sleep_req <= 1'b1;
      @(posedge aclk) sleep_req <= 1'b0;
      @(posedge aclk);
      chk("sleep refused", {31'h0, asleep}, 32'h0);
      // stop the counter, then check it holds
      wr(OFS_CTRL, 32'h0000_0000);
      wait_st(BIT_BUSY, 1'b0);
      rd(OFS_COUNT, c0);
      repeat (20) @(posedge aclk);
      rd(OFS_COUNT, v);
      chk("counter stopped", v, c0);
      wr(OFS_CTRL, 32'h0000_0002);
      wait_st(BIT_BUSY, 1'b0);
      rd(OFS_CTRL, v);
      chk("prescaler clear reads zero", v, 32'h0);
      // software drops wrap and alarm flags and the wake source
      wr(OFS_SCLR, 32'h0000_0101);
      wait_st(BIT_BUSY, 1'b0);
      chk("flags cleared", v & 32'h0000_0101, 32'h0);
      chk("irq dropped", {31'h0, irq}, 32'h0);
      chk("wake dropped", {31'h0, wake_req}, 32'h0);
      @(posedge aclk) sleep_req <= 1'b1;
      @(posedge aclk) sleep_req <= 1'b0;
      @(posedge aclk);
      chk("sleep taken", {31'h0, asleep}, 32'h1);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
